// File: hw/buck_cfg.svh
`ifndef BUCK_CFG_SVH
`define BUCK_CFG_SVH

// Register locations selected by the low bits of the command byte.
`define REG_CONTROL_ONE 6'h00
`define REG_CONTROL_TWO 6'h01
`define REG_OUTPUT_LEVEL 6'h02
`define REG_STATUS_FAULT 6'h03

// Fixed 7-bit serial address of the device.
`define DEVICE_ADDRESS 7'h5b

// Bits in one serial byte before its acknowledge slot.
`define BITS_PER_BYTE 4'h8

// Reserved bit of control one is never stored.
`define CONTROL_ONE_WMASK 8'hdf

// Reset value of the control bits that carry no factory value.
`define CLEAR_BITS_RESET 1'b0

// Enable delay per code, in microseconds.
`define ENABLE_DELAY_0_US 12'd250
`define ENABLE_DELAY_1_US 12'd1000
`define ENABLE_DELAY_2_US 12'd2000
`define ENABLE_DELAY_3_US 12'd3000

// Overtemperature cycles before latch-off.
`define OT_CYCLES_IMMEDIATE 3'd1
`define OT_CYCLES_DELAYED 3'd4

// Output-level decode.
`define LEVEL_FLOOR_CODE 8'h76
`define LEVEL_FIRST_STEP_CODE 8'h77
`define LEVEL_BASE_MV 11'd600
`define LEVEL_STEP_MV 11'd5

// Slew time grows by this many microseconds per volt for each code step.
`define SLEW_STEP_US 12'd200

`endif

// File: hw/buck_config_register_bank.sv
// Notes on behaviour
// [R1] Control one bits 7:6 pick low, medium, high or very high switching frequency.
// [R2] Control one bit 4 picks the lower or higher peak current limit.
// [R3] Control one bits 3:2 pick enable delay 250 us, 1 ms, 2 ms, 3 ms.
// [R4] Control one bit 1: 0 lets the register bit enable, 1 the pin.
// [R5] With register control, control one bit 0 turns the regulator off or on.
// [R6] Control two bit 7 set forbids full duty-cycle operation.
// [R7] Control two bit 6: 0 light-load mode, 1 forced continuous PWM.
// [R8] Control two bit 5: latch off at once, or after four overtemperature cycles.
// [R9] Control two bit 4 enables the output discharge while powered down.
// [R10] Control two bits 3:0 give slew time 200 us/V times code plus one.
// [R11] Output-level codes up to 0x76 all give the 0.6 V minimum.
// [R12] Codes 0x77 to 0xff rise from 0.6 V in 5 mV steps to 1.28 V.
// [R13] Power-on loads factory values into some fields and clears the other control bits.
// [R14] Low six bits of the command byte select the target register.
// [R15] Writes to unmapped locations are ignored; reads from them return zero.
// [R16] Fault register latch-off bit shows an overcurrent or overtemperature latch-off.
// [R17] Fault register ramp bit reads 1 once the output ramp has finished.
// [R18] Reserved control one bit 5 ignores writes and reads as zero.
// [R19] The fault register is read-only; writes leave it unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg.svh"

module buck_config_register_bank
  import buck_pkg::*;
#(
  parameter logic [1:0] ON_TIME_FACTORY = 2'h0,
  parameter logic PEAK_CURRENT_LIMIT_SELECT_FACTORY = 1'b0,
  parameter logic [5:0] CONTROL_TWO_LOW_FACTORY = 6'h00,
  parameter logic [7:0] LEVEL_FACTORY = 8'h00
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic enable_pin_i,
  input wire status_fault_t status_i,
  output logic regulator_on_o,
  output logic [1:0] on_time_select_o,
  output logic peak_current_limit_select_o,
  output logic [11:0] enable_delay_us_o,
  output logic full_duty_inhibit_o,
  output logic forced_pwm_mode_o,
  output logic light_load_mode_o,
  output logic [2:0] overtemp_latch_cycles_o,
  output logic discharge_on_o,
  output logic [10:0] output_level_mv_o,
  output logic [11:0] slew_us_per_v_o
);

  logic scl_s1_r, scl_s2_r, scl_s3_r, sda_s1_r, sda_s2_r, sda_s3_r, pin_s1_r, pin_s2_r;
  status_fault_t stat_s1_r, stat_s2_r, fault_view;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  serial_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt, rd_val;
  logic [5:0] sel_r, sel_nxt;
  logic rd_r, rd_nxt, more_r, more_nxt, oe_r, oe_nxt, wr_en;
  control_one_t control_one_r, control_one_nxt;
  control_two_t control_two_r, control_two_nxt;
  logic [7:0] level_r, level_nxt;

  logic on_nxt, peak_current_limit_select_nxt, fdi_nxt, forced_pwm_mode_nxt, llm_nxt, dis_nxt;
  logic [1:0] ton_nxt;
  logic [11:0] dly_nxt;
  logic [2:0] otc_nxt;

  function automatic logic [11:0] delay_us(input logic [1:0] code);
    case (code)
      2'h0: delay_us = `ENABLE_DELAY_0_US;
      2'h1: delay_us = `ENABLE_DELAY_1_US;
      2'h2: delay_us = `ENABLE_DELAY_2_US;
      default: delay_us = `ENABLE_DELAY_3_US;
    endcase
  endfunction

  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign bus_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  always_comb
  begin
    fault_view = stat_s2_r; // [R16] [R17]
    fault_view.enable_state = regulator_on_o;
    case (sel_r)
      `REG_CONTROL_ONE: rd_val = control_one_r & `CONTROL_ONE_WMASK; // [R18]
      `REG_CONTROL_TWO: rd_val = control_two_r;
      `REG_OUTPUT_LEVEL: rd_val = level_r;
      `REG_STATUS_FAULT: rd_val = fault_view;
      default: rd_val = 8'h00; // [R15]
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    sel_nxt = sel_r;
    rd_nxt = rd_r;
    more_nxt = more_r;
    oe_nxt = oe_r;
    control_one_nxt = control_one_r;
    control_two_nxt = control_two_r;
    level_nxt = level_r;
    wr_en = 1'b0;
    if (bus_stop)
    begin
      state_nxt = SER_IDLE;
      oe_nxt = 1'b0;
    end
    else if (bus_start)
    begin
      state_nxt = SER_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_r)
        SER_ADDR, SER_CMD, SER_WDATA:
        begin
          shift_nxt = {shift_r[6:0], sda_s2_r};
          cnt_nxt = cnt_r + 4'h1;
        end
        SER_RDATA: cnt_nxt = cnt_r + 4'h1;
        SER_RACK: more_nxt = ~sda_s2_r;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_r)
        SER_ADDR:
          if (cnt_r == `BITS_PER_BYTE)
          begin
            cnt_nxt = 4'h0;
            if (shift_r[7:1] == `DEVICE_ADDRESS)
            begin
              oe_nxt = 1'b1;
              rd_nxt = shift_r[0];
              tx_nxt = rd_val;
              state_nxt = SER_ACK_ADDR;
            end
            else
              state_nxt = SER_IDLE;
          end
        SER_CMD:
          if (cnt_r == `BITS_PER_BYTE)
          begin
            sel_nxt = shift_r[5:0]; // [R14]
            oe_nxt = 1'b1;
            state_nxt = SER_ACK_CMD;
          end
        SER_WDATA:
          if (cnt_r == `BITS_PER_BYTE)
          begin
            wr_en = 1'b1;
            oe_nxt = 1'b1;
            state_nxt = SER_ACK_WDATA;
          end
        SER_ACK_ADDR:
        begin
          cnt_nxt = 4'h0;
          oe_nxt = rd_r & ~tx_r[7];
          state_nxt = rd_r ? SER_RDATA : SER_CMD;
        end
        SER_ACK_CMD, SER_ACK_WDATA:
        begin
          cnt_nxt = 4'h0;
          oe_nxt = 1'b0;
          state_nxt = SER_WDATA;
        end
        SER_RDATA:
          if (cnt_r == `BITS_PER_BYTE)
          begin
            oe_nxt = 1'b0;
            state_nxt = SER_RACK;
          end
          else
          begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = ~tx_r[6];
          end
        SER_RACK:
          if (more_r)
          begin
            tx_nxt = rd_val;
            oe_nxt = ~rd_val[7];
            cnt_nxt = 4'h0;
            state_nxt = SER_RDATA;
          end
          else
            state_nxt = SER_IDLE;
        default: state_nxt = SER_IDLE;
      endcase
    end
    if (wr_en)
    begin
      case (sel_r)
        `REG_CONTROL_ONE: control_one_nxt = shift_r & `CONTROL_ONE_WMASK; // [R18]
        `REG_CONTROL_TWO: control_two_nxt = shift_r;
        `REG_OUTPUT_LEVEL: level_nxt = shift_r;
        default: ; // [R15] [R19]
      endcase
    end
  end

  always_comb
  begin
    on_nxt = control_one_r.enable_from_pin ? pin_s2_r : control_one_r.soft_enable_value; // [R4] [R5]
    ton_nxt = control_one_r.on_time_select; // [R1]
    peak_current_limit_select_nxt = control_one_r.peak_current_limit_select; // [R2]
    dly_nxt = delay_us(control_one_r.enable_delay_select); // [R3]
    fdi_nxt = control_two_r.full_duty_inhibit; // [R6]
    forced_pwm_mode_nxt = control_two_r.forced_pwm_mode; // [R7]
    llm_nxt = ~control_two_r.forced_pwm_mode; // [R7]
    otc_nxt = control_two_r.overtemp_latch_policy ? `OT_CYCLES_DELAYED : `OT_CYCLES_IMMEDIATE; // [R8]
    dis_nxt = control_two_r.discharge_enable & ~on_nxt; // [R9]
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {scl_s1_r, scl_s2_r, scl_s3_r, sda_s1_r, sda_s2_r, sda_s3_r} <= 6'h3f;
      {pin_s1_r, pin_s2_r} <= 2'h0;
      stat_s1_r <= '0;
      stat_s2_r <= '0;
      state_r <= SER_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      sel_r <= 6'h00;
      rd_r <= 1'b0;
      more_r <= 1'b0;
      oe_r <= 1'b0;
      control_one_r <= {ON_TIME_FACTORY, `CLEAR_BITS_RESET, PEAK_CURRENT_LIMIT_SELECT_FACTORY, 4'h0}; // [R13]
      control_two_r <= {2'h0, CONTROL_TWO_LOW_FACTORY}; // [R13]
      level_r <= LEVEL_FACTORY; // [R13]
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      regulator_on_o <= 1'b0;
      on_time_select_o <= 2'h0;
      peak_current_limit_select_o <= 1'b0;
      enable_delay_us_o <= `ENABLE_DELAY_0_US;
      full_duty_inhibit_o <= 1'b0;
      forced_pwm_mode_o <= 1'b0;
      light_load_mode_o <= 1'b1;
      overtemp_latch_cycles_o <= `OT_CYCLES_IMMEDIATE;
      discharge_on_o <= 1'b0;
    end
    else
    begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_i, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_i, sda_s1_r, sda_s2_r};
      {pin_s1_r, pin_s2_r} <= {enable_pin_i, pin_s1_r};
      stat_s1_r <= status_i;
      stat_s2_r <= stat_s1_r;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
      more_r <= more_nxt;
      oe_r <= oe_nxt;
      control_one_r <= control_one_nxt;
      control_two_r <= control_two_nxt;
      level_r <= level_nxt;
      sda_o <= 1'b0;
      sda_oe_o <= oe_nxt;
      regulator_on_o <= on_nxt;
      on_time_select_o <= ton_nxt;
      peak_current_limit_select_o <= peak_current_limit_select_nxt;
      enable_delay_us_o <= dly_nxt;
      full_duty_inhibit_o <= fdi_nxt;
      forced_pwm_mode_o <= forced_pwm_mode_nxt;
      light_load_mode_o <= llm_nxt;
      overtemp_latch_cycles_o <= otc_nxt;
      discharge_on_o <= dis_nxt;
    end
  end

  level_decode u_level_decode (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .code_i(level_r),
    .slew_code_i(control_two_r.slew_select),
    .level_mv_o(output_level_mv_o),
    .slew_us_o(slew_us_per_v_o)
  );

  chk_enable_source: assert property (@(posedge clock_i) disable iff (rst_i) // [R4]
    control_one_r.enable_from_pin |=> regulator_on_o == $past(pin_s2_r))
    else $error("pin source not followed");

  chk_soft_enable: assert property (@(posedge clock_i) disable iff (rst_i) // [R5]
    !control_one_r.enable_from_pin |=> regulator_on_o == $past(control_one_r.soft_enable_value))
    else $error("register enable not followed");

  chk_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i) // [R18]
    wr_en && sel_r == 6'h00 |=> !control_one_r.reserved && control_one_r[7:6] == $past(shift_r[7:6]))
    else $error("reserved bit stored or field lost");

  chk_unmapped_ignored: assert property (@(posedge clock_i) disable iff (rst_i) // [R15]
    wr_en && sel_r > 6'h02 |=> $stable(control_one_r) && $stable(control_two_r) && $stable(level_r))
    else $error("write to fault or unmapped location changed a register");

  chk_command_select: assert property (@(posedge clock_i) disable iff (rst_i) // [R14]
    state_r == SER_CMD && scl_fall && cnt_r == 4'h8 |=> sel_r == $past(shift_r[5:0]) && sda_oe_o)
    else $error("command byte not taken or not acknowledged");

  chk_unmapped_read: assert property (@(posedge clock_i) disable iff (rst_i) // [R15]
    state_r == SER_ADDR && scl_fall && cnt_r == 4'h8 && shift_r == 8'hb7 && sel_r > 6'h03
      |=> tx_r == 8'h00 && sda_oe_o)
    else $error("unmapped read not zero");

  chk_latch_cycles: assert property (@(posedge clock_i) disable iff (rst_i) // [R8]
    1'b1 |=> overtemp_latch_cycles_o == ($past(control_two_r.overtemp_latch_policy) ? 3'd4 : 3'd1))
    else $error("latch cycle count wrong");

  chk_discharge: assert property (@(posedge clock_i) disable iff (rst_i) // [R9]
    discharge_on_o |-> !regulator_on_o && $past(control_two_r.discharge_enable))
    else $error("discharge while on or not enabled");

  chk_delay_decode: assert property (@(posedge clock_i) disable iff (rst_i) // [R3]
    control_one_r.enable_delay_select == 2'h0 |=> enable_delay_us_o == 12'd250)
    else $error("enable delay decode wrong");

  chk_fault_mirror: assert property (@(posedge clock_i) disable iff (rst_i) // [R16]
    sel_r == 6'h03 |-> rd_val[1] == $past(status_i.latched_off, 2)
      && rd_val[4] == $past(status_i.ramp_complete_flag, 2))
    else $error("fault register does not mirror status");

endmodule
`default_nettype wire

// File: hw/buck_pkg.sv
package buck_pkg;

  typedef struct packed {
    logic [1:0] on_time_select;
    logic reserved;
    logic peak_current_limit_select;
    logic [1:0] enable_delay_select;
    logic enable_from_pin;
    logic soft_enable_value;
  } control_one_t;

  typedef struct packed {
    logic full_duty_inhibit;
    logic forced_pwm_mode;
    logic overtemp_latch_policy;
    logic discharge_enable;
    logic [3:0] slew_select;
  } control_two_t;

  typedef struct packed {
    logic overtemp_warning;
    logic enable_state;
    logic boot_error;
    logic ramp_complete_flag;
    logic hiccup_active;
    logic overtemp_fault;
    logic latched_off;
    logic power_good_flag;
  } status_fault_t;

  typedef enum logic [3:0] {
    SER_IDLE = 4'b0000,
    SER_ADDR = 4'b0001,
    SER_ACK_ADDR = 4'b0010,
    SER_CMD = 4'b0011,
    SER_ACK_CMD = 4'b0100,
    SER_WDATA = 4'b0101,
    SER_ACK_WDATA = 4'b0110,
    SER_RDATA = 4'b0111,
    SER_RACK = 4'b1000
  } serial_state_t;

endpackage

// File: hw/level_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg.svh"

module level_decode
  import buck_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] code_i,
  input wire logic [3:0] slew_code_i,
  output logic [10:0] level_mv_o,
  output logic [11:0] slew_us_o
);

  logic [10:0] level_nxt;
  logic [11:0] slew_nxt;

  function automatic logic [10:0] code_to_mv(input logic [7:0] code);
    logic [10:0] steps;
    steps = {3'b000, code - `LEVEL_FIRST_STEP_CODE};
    if (code <= `LEVEL_FLOOR_CODE)
      code_to_mv = `LEVEL_BASE_MV; // [R11]
    else
      code_to_mv = 11'(`LEVEL_BASE_MV + steps * `LEVEL_STEP_MV); // [R12]
  endfunction

  always_comb
  begin
    level_nxt = code_to_mv(code_i);
    slew_nxt = 12'(`SLEW_STEP_US * ({8'h00, slew_code_i} + 12'd1)); // [R10]
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level_mv_o <= `LEVEL_BASE_MV;
      slew_us_o <= `SLEW_STEP_US;
    end
    else
    begin
      level_mv_o <= level_nxt;
      slew_us_o <= slew_nxt;
    end
  end

  chk_level_floor: assert property (@(posedge clock_i) disable iff (rst_i) // [R11]
    code_i <= 8'h76 |=> level_mv_o == 11'd600)
    else $error("level below floor code not at minimum");

  chk_level_step: assert property (@(posedge clock_i) disable iff (rst_i) // [R12]
    (code_i == 8'hff) || (code_i == 8'h78) |=>
      level_mv_o == (($past(code_i) == 8'hff) ? 11'd1280 : 11'd605))
    else $error("level step decode wrong");

  chk_slew_decode: assert property (@(posedge clock_i) disable iff (rst_i) // [R10]
    slew_code_i == 4'hf ##1 slew_code_i == 4'h0 |-> slew_us_o == 12'd3200 ##1 slew_us_o == 12'd200)
    else $error("slew decode wrong");

endmodule
`default_nettype wire

// File: sim/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic half();
    repeat (10) @(negedge clock_i);
  endtask

  // Data moves only a little after the clock has fallen, so it changes while the clock is high only in start and stop conditions.
  task automatic start_cond();
    repeat (2) @(negedge clock_i);
    sda_pull_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_pull_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    repeat (2) @(negedge clock_i);
    sda_pull_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_pull_o = 1'b0;
    half();
  endtask

  task automatic clk_bit(input logic b, output logic r);
    repeat (2) @(negedge clock_i);
    sda_pull_o = ~b;
    half();
    scl_o = 1'b1;
    half();
    r = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic byte_rx(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(nack, r);
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd, input logic [7:0] data, output logic ok);
    logic a;
    logic b;
    logic c;
    start_cond();
    byte_tx({addr, 1'b0}, a);
    byte_tx(cmd, b);
    byte_tx(data, c);
    stop_cond();
    ok = a & b & c;
  endtask

  // The last byte of a read is refused by the host so that the device lets go of the line.
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd, output logic [7:0] d);
    logic a;
    start_cond();
    byte_tx({addr, 1'b0}, a);
    byte_tx(cmd, a);
    start_cond();
    byte_tx({addr, 1'b1}, a);
    byte_rx(1'b1, d);
    stop_cond();
  endtask

  // The host acknowledges the first byte, so the device sends a second one before the refusal.
  task automatic read_pair(input logic [6:0] addr, input logic [7:0] cmd, output logic [7:0] d0, output logic [7:0] d1);
    logic a;
    start_cond();
    byte_tx({addr, 1'b0}, a);
    byte_tx(cmd, a);
    start_cond();
    byte_tx({addr, 1'b1}, a);
    byte_rx(1'b0, d0);
    byte_rx(1'b1, d1);
    stop_cond();
  endtask
endmodule

`default_nettype wire

// File: sim/tb_buck_config_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg.svh"

module tb_buck_config_register_bank
  import buck_pkg::*;
;
  logic clk = 1'b0;
  logic rst;
  logic enable_pin;
  status_fault_t status;
  logic scl;
  logic host_pull;
  logic dut_sda;
  logic dut_oe;
  logic sda_line;
  logic regulator_on;
  logic [1:0] on_time;
  logic cur_limit;
  logic [11:0] en_delay;
  logic full_duty;
  logic forced_pwm;
  logic light_load;
  logic [2:0] latch_cycles;
  logic discharge;
  logic [10:0] level_mv;
  logic [11:0] slew_us;
  logic [7:0] flags;
  int n_errors = 0;
  int n_checks = 0;

  assign sda_line = ~(dut_oe | host_pull);
  assign flags = {on_time, cur_limit, full_duty, forced_pwm, light_load, discharge, regulator_on};

  always #25 clk = ~clk;

  buck_config_register_bank dut (
    .clock_i(clk),
    .rst_i(rst),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(dut_sda),
    .sda_oe_o(dut_oe),
    .enable_pin_i(enable_pin),
    .status_i(status),
    .regulator_on_o(regulator_on),
    .on_time_select_o(on_time),
    .peak_current_limit_select_o(cur_limit),
    .enable_delay_us_o(en_delay),
    .full_duty_inhibit_o(full_duty),
    .forced_pwm_mode_o(forced_pwm),
    .light_load_mode_o(light_load),
    .overtemp_latch_cycles_o(latch_cycles),
    .discharge_on_o(discharge),
    .output_level_mv_o(level_mv),
    .slew_us_per_v_o(slew_us)
  );

  serial_host_model host (
    .clock_i(clk),
    .sda_i(sda_line),
    .scl_o(scl),
    .sda_pull_o(host_pull)
  );

  task automatic cmp_out(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic cmp_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_expect(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(`DEVICE_ADDRESS, cmd, d);
    cmp_reg("register read", exp, d);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic ok;
    host.write_reg(`DEVICE_ADDRESS, cmd, d, ok);
    cmp_out("write ack", 12'h001, {11'h000, ok});
  endtask

  task automatic test_reset();
    cmp_out("flags", 12'h004, {4'h0, flags});
    cmp_out("enable delay", 12'd250, en_delay);
    cmp_out("latch cycles", 12'd1, {9'h000, latch_cycles});
    cmp_out("level", 12'd600, {1'b0, level_mv});
    cmp_out("slew", 12'd200, slew_us);
    cmp_out("sda out", 12'h000, {11'h000, dut_sda});
    for (int c = 0; c < 3; c++)
      reg_expect(c[7:0], 8'h00);
    $display("test reset done");
  endtask

  task automatic test_control_one();
    logic [11:0] dly [4] = '{12'd250, 12'd1000, 12'd2000, 12'd3000};
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = {i[1:0], 1'b1, i[0], i[1:0], 2'b00};
      wr(8'h00, v);
      cmp_out("on time", {10'h000, i[1:0]}, {10'h000, on_time});
      cmp_out("current limit", {11'h000, i[0]}, {11'h000, cur_limit});
      cmp_out("enable delay", dly[i], en_delay);
      reg_expect(8'h00, v & 8'hdf);
    end
    $display("test control one done");
  endtask

  task automatic test_control_two();
    logic [7:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = {i[0], i[1], i[2], 1'b0, i[3:0]};
      wr(8'h01, v);
      cmp_out("full duty", {11'h000, i[0]}, {11'h000, full_duty});
      cmp_out("forced pwm", {10'h000, i[1], ~i[1]}, {10'h000, forced_pwm, light_load});
      cmp_out("latch cycles", i[2] ? 12'd4 : 12'd1, {9'h000, latch_cycles});
      cmp_out("slew", 12'(200 * (i + 1)), slew_us);
      reg_expect(8'h01, v);
    end
    $display("test control two done");
  endtask

  task automatic test_enable();
    logic src;
    logic exp;
    wr(8'h01, 8'h10);
    for (int k = 0; k < 4; k++)
    begin
      src = k[1];
      enable_pin = ~k[0];
      exp = src ? ~k[0] : k[0];
      wr(8'h00, {6'h00, src, k[0]});
      cmp_out("regulator on", {11'h000, exp}, {11'h000, regulator_on});
      cmp_out("discharge", {11'h000, ~exp}, {11'h000, discharge});
    end
    $display("test enable done");
  endtask

  task automatic test_level();
    logic [7:0] codes [6] = '{8'h00, 8'h76, 8'h77, 8'h78, 8'hc7, 8'hff};
    logic [7:0] c;
    logic [7:0] d0;
    logic [7:0] d1;
    for (int i = 0; i < 6; i++)
    begin
      c = codes[i];
      wr(8'h02, c);
      cmp_out("level", (c <= 8'h76) ? 12'd600 : 12'(600 + 5 * (c - 8'h77)), {1'b0, level_mv});
      reg_expect(8'h02, c);
    end
    host.read_pair(`DEVICE_ADDRESS, 8'h02, d0, d1);
    cmp_reg("read first", 8'hff, d0);
    cmp_reg("read again", 8'hff, d1);
    $display("test level done");
  endtask

  task automatic test_fault();
    logic [7:0] pats [2] = '{8'h12, 8'hed};
    logic [7:0] p;
    for (int i = 0; i < 2; i++)
    begin
      p = pats[i];
      status = p;
      repeat (4) @(negedge clk);
      reg_expect(8'h03, {p[7], 1'b0, p[5:0]});
      wr(8'h03, ~p);
      reg_expect(8'h03, {p[7], 1'b0, p[5:0]});
    end
    $display("test fault done");
  endtask

  task automatic test_unmapped();
    logic ok;
    wr(8'h04, 8'h5a);
    wr(8'h3f, 8'h5a);
    reg_expect(8'h04, 8'h00);
    reg_expect(8'h3f, 8'h00);
    reg_expect(8'h00, 8'h03);
    reg_expect(8'h01, 8'h10);
    wr(8'hc2, 8'h99);
    reg_expect(8'h02, 8'h99);
    host.write_reg(7'h2a, 8'h02, 8'h11, ok);
    cmp_out("foreign ack", 12'h000, {11'h000, ok});
    reg_expect(8'h02, 8'h99);
    $display("test unmapped done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    enable_pin = 1'b0;
    status = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    test_reset();
    test_control_one();
    test_control_two();
    test_enable();
    test_level();
    test_fault();
    test_unmapped();
    results();
  end

  // The tests take about 60000 cycles; this leaves generous room before a hang is declared.
  initial
  begin
    #(95000 * 50);
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    results();
  end
endmodule

`default_nettype wire
